/* File: src/flash_seq_defines.vh */
// Constants for the flash self-program sequencer
`ifndef FLASH_SEQ_DEFINES_VH
`define FLASH_SEQ_DEFINES_VH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define OFS_CONTROL 6'h00
`define OFS_POINTER_LOW 6'h04
`define OFS_POINTER_HIGH 6'h08
`define OFS_OPERAND_LOW 6'h0c
`define OFS_OPERAND_HIGH 6'h10
`define OFS_STORE 6'h14
`define OFS_LOCK_BITS 6'h18
`define OFS_LOAD_ADDR 6'h1c

// ------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------
`define BIT_STORE_ENABLE 0
`define BIT_ERASE 1
`define BIT_WRITE 2
`define BIT_LOCK_SET 3
`define BIT_REENABLE 4
`define BIT_BUSY 6
`define BIT_IRQ_ENABLE 7
`define CTRL_RESET 8'h00
`define CMD_NONE 5'h00

// ------------------------------------------------------------
// Command patterns in the lower five bits
// ------------------------------------------------------------
`define CMD_LOAD 5'h01
`define CMD_ERASE 5'h03
`define CMD_WRITE 5'h05
`define CMD_LOCK_SET 5'h09
`define CMD_REENABLE 5'h11

// ------------------------------------------------------------
// Lock bits and timing
// ------------------------------------------------------------
`define LOCK_LSB 2
`define LOCK_RESET 4'hf
`define STORE_WINDOW 3'h4
`define CLK_MHZ 100
`define PROG_TIME_US 3700
`define PROG_CYCLES (`PROG_TIME_US * `CLK_MHZ)

// ------------------------------------------------------------
// Bus responses
// ------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: src/page_buffer.v */
// Temporary page buffer held in flip-flops
module page_buffer #(
	parameter WORD_BITS = 6,
	parameter DATA_BITS = 16
) (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// Clear whole buffer
	input wire clear,
	// Write port
	input wire wr_en,
	input wire [WORD_BITS-1:0] wr_index,
	input wire [DATA_BITS-1:0] wr_data,
	// Read port
	input wire [WORD_BITS-1:0] rd_index,
	output wire [DATA_BITS-1:0] rd_data
);
	localparam DEPTH = 1 << WORD_BITS;

	reg [DATA_BITS-1:0] mem [0:DEPTH-1];
	integer i;

	assign rd_data = mem[rd_index];

	// ------------------------------------------------------------
	// Storage; erased state reads as all ones
	// ------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn || clear) begin
			for (i = 0; i < DEPTH; i = i + 1) begin
				mem[i] <= {DATA_BITS{1'b1}};
			end
		end else if (wr_en) begin
			mem[wr_index] <= wr_data;
		end
	end
endmodule

/* File: src/flash_self_program_sequencer.v */
// Flash self-program sequencer with AXI4-Lite register access
//
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`include "flash_seq_defines.vh"

module flash_self_program_sequencer #(
	parameter WORD_BITS = 6,
	parameter PAGE_BITS = 8,
	parameter STALL_FIRST_PAGE = 224,
	parameter PROG_CYCLES = `PROG_CYCLES,
	parameter TIMER_BITS = 20
) (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// AXI4-Lite write address
	input wire awvalid,
	output reg awready,
	input wire [5:0] awaddr,
	input wire [2:0] awprot,
	// AXI4-Lite write data
	input wire wvalid,
	output reg wready,
	input wire [31:0] wdata,
	input wire [3:0] wstrb,
	// AXI4-Lite write response
	output reg bvalid,
	input wire bready,
	output reg [1:0] bresp,
	// AXI4-Lite read address
	input wire arvalid,
	output reg arready,
	input wire [5:0] araddr,
	input wire [2:0] arprot,
	// AXI4-Lite read data
	output reg rvalid,
	input wire rready,
	output reg [31:0] rdata,
	output reg [1:0] rresp,
	// EEPROM activity
	input wire eeprom_write,
	// Flash array side
	output reg array_erase,
	output reg array_wr_en,
	output reg [PAGE_BITS+WORD_BITS-1:0] array_wr_addr,
	output reg [15:0] array_wr_data,
	output reg [PAGE_BITS-1:0] array_page,
	// Program-memory load address
	output reg [PAGE_BITS+WORD_BITS-1:0] load_word_addr,
	output reg pointer_byte_select,
	// Core status
	output reg cpu_halt,
	output reg concurrent_read_blocked,
	output reg store_ready_irq
);
	localparam S_IDLE = 2'h0;
	localparam S_ARMED = 2'h1;
	localparam S_OUT = 2'h2;
	localparam S_WAIT = 2'h3;
	localparam [WORD_BITS-1:0] LAST_WORD = {WORD_BITS{1'b1}};

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	reg [1:0] state;
	reg [4:0] cmd;
	reg store_ready_irq_enable;
	reg concurrent_section_busy_flag;
	reg [2:0] window;
	reg [TIMER_BITS-1:0] timer;
	reg [7:0] flash_pointer_low;
	reg [7:0] flash_pointer_high;
	reg [7:0] low_operand_register;
	reg [7:0] high_operand_register;
	reg [3:0] boot_lock;
	reg loading;
	reg [PAGE_BITS-1:0] op_page;
	reg [WORD_BITS-1:0] out_index;
	reg aw_full;
	reg w_full;
	reg [5:0] wr_addr;
	reg [31:0] wr_data;
	reg [3:0] wr_strb;

	wire [15:0] pointer = {flash_pointer_high, flash_pointer_low};
	wire [WORD_BITS-1:0] word_index_field = pointer[WORD_BITS:1];
	wire [PAGE_BITS-1:0] page_index_field =
		pointer[PAGE_BITS+WORD_BITS:WORD_BITS+1];
	wire store_enable_bit = (state != S_IDLE);
	wire [15:0] buf_rd_data;

	// ------------------------------------------------------------
	// Bus write decode
	// ------------------------------------------------------------
	wire do_write = aw_full && w_full && !bvalid;
	wire lane0 = wr_strb[0];
	wire wr_ctrl = do_write && lane0 && wr_addr == `OFS_CONTROL;
	wire wr_store = do_write && lane0 && wr_addr == `OFS_STORE;
	wire [4:0] new_cmd = wr_data[4:0];
	wire cmd_valid = new_cmd == `CMD_LOAD || new_cmd == `CMD_ERASE ||
		new_cmd == `CMD_WRITE || new_cmd == `CMD_LOCK_SET ||
		new_cmd == `CMD_REENABLE;
	wire arm = wr_ctrl && cmd_valid && state == S_IDLE && !eeprom_write;
	wire store_hit = wr_store && state == S_ARMED;
	wire do_load = store_hit && cmd == `CMD_LOAD;
	wire do_reenable = store_hit && cmd == `CMD_REENABLE;
	wire write_done = state == S_OUT && out_index == LAST_WORD;
	wire buf_clear = write_done || do_reenable ||
		(eeprom_write && loading);

	function mapped;
		input [5:0] a;
		begin
			if (a == `OFS_CONTROL || a == `OFS_POINTER_LOW ||
				a == `OFS_POINTER_HIGH || a == `OFS_OPERAND_LOW ||
				a == `OFS_OPERAND_HIGH || a == `OFS_STORE ||
				a == `OFS_LOCK_BITS || a == `OFS_LOAD_ADDR) begin
				mapped = 1'b1;
			end else begin
				mapped = 1'b0;
			end
		end
	endfunction

	// ------------------------------------------------------------
	// Temporary page buffer
	// ------------------------------------------------------------
	page_buffer #(
		.WORD_BITS(WORD_BITS),
		.DATA_BITS(16)
	) u_buffer (
		.aclk(aclk),
		.aresetn(aresetn),
		.clear(buf_clear),
		.wr_en(do_load),
		.wr_index(word_index_field),
		.wr_data({high_operand_register, low_operand_register}),
		.rd_index(out_index),
		.rd_data(buf_rd_data)
	);

	// ------------------------------------------------------------
	// AXI4-Lite write channels
	// ------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b0;
			wready <= 1'b0;
			aw_full <= 1'b0;
			w_full <= 1'b0;
			bvalid <= 1'b0;
			bresp <= `RESP_OKAY;
			wr_addr <= 6'h00;
			wr_data <= 32'h00000000;
			wr_strb <= 4'h0;
		end else begin
			awready <= !aw_full && !(awvalid && awready);
			wready <= !w_full && !(wvalid && wready);
			if (awvalid && awready) begin
				aw_full <= 1'b1;
				wr_addr <= {awaddr[5:2], 2'b00};
			end
			if (wvalid && wready) begin
				w_full <= 1'b1;
				wr_data <= wdata;
				wr_strb <= wstrb;
			end
			if (do_write) begin
				bvalid <= 1'b1;
				bresp <= mapped(wr_addr) ? `RESP_OKAY : `RESP_SLVERR;
			end
			if (bvalid && bready) begin
				bvalid <= 1'b0;
				aw_full <= 1'b0;
				w_full <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite read channels
	// ------------------------------------------------------------
	function [31:0] read_mux;
		input [5:0] a;
		begin
			read_mux = 32'h00000000;
			if (a == `OFS_CONTROL) begin
				read_mux[`BIT_IRQ_ENABLE] = store_ready_irq_enable;
				read_mux[`BIT_BUSY] = concurrent_section_busy_flag;
				read_mux[4:1] = store_enable_bit ? cmd[4:1] : 4'h0;
				read_mux[`BIT_STORE_ENABLE] = store_enable_bit;
			end else if (a == `OFS_POINTER_LOW) begin
				read_mux[7:0] = flash_pointer_low;
			end else if (a == `OFS_POINTER_HIGH) begin
				read_mux[7:0] = flash_pointer_high;
			end else if (a == `OFS_OPERAND_LOW) begin
				read_mux[7:0] = low_operand_register;
			end else if (a == `OFS_OPERAND_HIGH) begin
				read_mux[7:0] = high_operand_register;
			end else if (a == `OFS_LOCK_BITS) begin
				read_mux[`LOCK_LSB+3:`LOCK_LSB] = boot_lock;
			end else if (a == `OFS_LOAD_ADDR) begin
				read_mux[15:0] = pointer;
			end
		end
	endfunction

	always @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= `RESP_OKAY;
		end else begin
			arready <= !rvalid && !(arvalid && arready);
			if (arvalid && arready) begin
				rvalid <= 1'b1;
				rdata <= read_mux({araddr[5:2], 2'b00});
				rresp <= mapped({araddr[5:2], 2'b00}) ?
					`RESP_OKAY : `RESP_SLVERR;
			end else if (rvalid && rready) begin
				rvalid <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Software registers
	// ------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			flash_pointer_low <= 8'h00;
			flash_pointer_high <= 8'h00;
			low_operand_register <= 8'h00;
			high_operand_register <= 8'h00;
			store_ready_irq_enable <= 1'b0;
		end else if (do_write && lane0) begin
			if (wr_addr == `OFS_CONTROL) begin
				store_ready_irq_enable <= wr_data[`BIT_IRQ_ENABLE];
			end else if (wr_addr == `OFS_POINTER_LOW) begin
				flash_pointer_low <= wr_data[7:0];
			end else if (wr_addr == `OFS_POINTER_HIGH) begin
				flash_pointer_high <= wr_data[7:0];
			end else if (wr_addr == `OFS_OPERAND_LOW) begin
				low_operand_register <= wr_data[7:0];
			end else if (wr_addr == `OFS_OPERAND_HIGH) begin
				high_operand_register <= wr_data[7:0];
			end
		end
	end

	// ------------------------------------------------------------
	// Command sequencer
	// ------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			state <= S_IDLE;
			cmd <= `CMD_NONE;
			window <= 3'h0;
			timer <= {TIMER_BITS{1'b0}};
			concurrent_section_busy_flag <= 1'b0;
			boot_lock <= `LOCK_RESET;
			loading <= 1'b0;
			op_page <= {PAGE_BITS{1'b0}};
			out_index <= {WORD_BITS{1'b0}};
			cpu_halt <= 1'b0;
			array_erase <= 1'b0;
			array_wr_en <= 1'b0;
			array_wr_addr <= {(PAGE_BITS+WORD_BITS){1'b0}};
			array_wr_data <= 16'h0000;
			array_page <= {PAGE_BITS{1'b0}};
		end else begin
			array_erase <= 1'b0;
			array_wr_en <= 1'b0;
			if (buf_clear) begin
				loading <= 1'b0;
			end
			case (state)
			S_IDLE: begin
				if (arm) begin
					cmd <= new_cmd;
					window <= `STORE_WINDOW;
					state <= S_ARMED;
				end
			end
			S_ARMED: begin
				if (store_hit) begin
					if (cmd == `CMD_LOAD) begin
						loading <= 1'b1;
						concurrent_section_busy_flag <= 1'b0;
						state <= S_IDLE;
					end else if (cmd == `CMD_REENABLE) begin
						concurrent_section_busy_flag <= 1'b0;
						state <= S_IDLE;
					end else if (cmd == `CMD_LOCK_SET) begin
						// Only boot lock bits, programmed where zero
						boot_lock <= boot_lock &
							low_operand_register[`LOCK_LSB+3:`LOCK_LSB];
						timer <= PROG_CYCLES[TIMER_BITS-1:0];
						state <= S_WAIT;
					end else begin
						// Page latched; operand registers unused
						op_page <= page_index_field;
						concurrent_section_busy_flag <= 1'b1;
						cpu_halt <= page_index_field >=
							STALL_FIRST_PAGE;
						timer <= PROG_CYCLES[TIMER_BITS-1:0];
						if (cmd == `CMD_ERASE) begin
							array_erase <= 1'b1;
							array_page <= page_index_field;
							state <= S_WAIT;
						end else begin
							out_index <= {WORD_BITS{1'b0}};
							state <= S_OUT;
						end
					end
				end else if (window == 3'h1) begin
					state <= S_IDLE;
				end else begin
					window <= window - 3'h1;
				end
			end
			S_OUT: begin
				array_wr_en <= 1'b1;
				array_wr_addr <= {op_page, out_index};
				array_wr_data <= buf_rd_data;
				array_page <= op_page;
				out_index <= out_index + {{(WORD_BITS-1){1'b0}}, 1'b1};
				if (write_done) begin
					state <= S_WAIT;
				end
			end
			S_WAIT: begin
				// Store enable stays set until programming ends
				if (timer <= {{(TIMER_BITS-1){1'b0}}, 1'b1}) begin
					cpu_halt <= 1'b0;
					state <= S_IDLE;
				end else begin
					timer <= timer - {{(TIMER_BITS-1){1'b0}}, 1'b1};
				end
			end
			default: begin
				state <= S_IDLE;
			end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Registered status outputs
	// ------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			concurrent_read_blocked <= 1'b0;
			store_ready_irq <= 1'b0;
			load_word_addr <= {(PAGE_BITS+WORD_BITS){1'b0}};
			pointer_byte_select <= 1'b0;
		end else begin
			concurrent_read_blocked <= concurrent_section_busy_flag;
			store_ready_irq <= store_ready_irq_enable &&
				!store_enable_bit;
			load_word_addr <= pointer[PAGE_BITS+WORD_BITS:1];
			pointer_byte_select <= pointer[0];
		end
	end
endmodule

/* File: test/flash_seq_chk.sv */
// Port assertions for the flash self-program sequencer
module flash_seq_chk #(
	parameter WORD_BITS = 6,
	parameter PAGE_BITS = 8,
	parameter STALL_FIRST_PAGE = 224
) (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// Bus response
	input wire bvalid,
	input wire [1:0] bresp,
	// Array and status
	input wire array_erase,
	input wire [PAGE_BITS-1:0] array_page,
	input wire array_wr_en,
	input wire [PAGE_BITS+WORD_BITS-1:0] array_wr_addr,
	input wire cpu_halt,
	input wire concurrent_read_blocked,
	input wire store_ready_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_erase_pulse: assert property (
		array_erase |=> !array_erase) else $error("Erase pulse too long");
	a_erase_block: assert property (
		array_erase |=> concurrent_read_blocked) else $error("Busy not set");
	a_erase_halt: assert property (
		array_erase |-> ##2
		(cpu_halt == ($past(array_page, 2) >= STALL_FIRST_PAGE)))
		else $error("Halt wrong during erase");
	a_irq_quiet: assert property (
		array_erase |-> ##1 (!store_ready_irq)[*4])
		else $error("Ready request while busy");
	a_wr_burst: assert property (
		$rose(array_wr_en) |-> array_wr_en[*8]) else $error("Burst cut");
	a_wr_step: assert property (
		array_wr_en && $past(array_wr_en) |->
		array_wr_addr == $past(array_wr_addr) + 1'h1)
		else $error("Word address not stepping");
	a_wr_halt: assert property (
		array_wr_en && $past(array_wr_en) |-> cpu_halt ==
		(array_wr_addr[PAGE_BITS+WORD_BITS-1:WORD_BITS] >= STALL_FIRST_PAGE))
		else $error("Halt wrong during write");
	a_wr_block: assert property (
		array_wr_en && $past(array_wr_en) |-> concurrent_read_blocked)
		else $error("Busy not set during write");
	cover property (array_erase && array_page >= STALL_FIRST_PAGE);
	cover property ($rose(array_wr_en));
	cover property (bvalid && bresp == 2'h2);
endmodule

bind flash_self_program_sequencer flash_seq_chk #(.WORD_BITS(WORD_BITS),
	.PAGE_BITS(PAGE_BITS), .STALL_FIRST_PAGE(STALL_FIRST_PAGE))
	flash_seq_chk_inst (.aclk(aclk), .aresetn(aresetn), .bvalid(bvalid),
	.bresp(bresp), .array_erase(array_erase), .array_page(array_page),
	.array_wr_en(array_wr_en), .array_wr_addr(array_wr_addr),
	.cpu_halt(cpu_halt), .concurrent_read_blocked(concurrent_read_blocked),
	.store_ready_irq(store_ready_irq));

/* File: test/flash_array_model.sv */
// Behavioural flash array behind the sequencer
module flash_array_model #(
	parameter WORD_BITS = 6,
	parameter PAGE_BITS = 8
) (
	// Clock
	input wire aclk,
	// Array commands
	input wire array_erase,
	input wire [PAGE_BITS-1:0] array_page,
	input wire array_wr_en,
	input wire [PAGE_BITS+WORD_BITS-1:0] array_wr_addr,
	input wire [15:0] array_wr_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [0:(1<<(PAGE_BITS+WORD_BITS))-1];
	int n_ops = 0;
	// Erase sets a page to ones, write only clears bits
	always @(posedge aclk) begin
		if (array_erase) begin
			n_ops++;
			for (int i = 0; i < (1 << WORD_BITS); i++) begin
				mem[{array_page, i[WORD_BITS-1:0]}] <= 16'hffff;
			end
		end
		if (array_wr_en) begin
			n_ops++;
			mem[array_wr_addr] <= mem[array_wr_addr] & array_wr_data;
		end
	end
endmodule

/* File: test/flash_self_program_sequencer_tb.sv */
// Self-checking bench for the flash self-program sequencer
`include "flash_seq_defines.vh"
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin \
	n_fail++; $display("Error %s expected %h seen %h", nm, ex, got); end end

module flash_self_program_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
	logic arvalid = 0, rready = 0, eeprom_write = 0;
	logic [5:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, d;
	logic [1:0] r;
	wire awready, wready, bvalid, arready, rvalid, array_erase, array_wr_en;
	wire pointer_byte_select, cpu_halt, concurrent_read_blocked;
	wire store_ready_irq;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [7:0] array_page;
	wire [13:0] array_wr_addr, load_word_addr;
	wire [15:0] array_wr_data;
	int n_fail = 0, total_checks = 0, cycles = 0, n;

	flash_self_program_sequencer #(.PROG_CYCLES(20))
		flash_self_program_sequencer_inst (.aclk(aclk), .aresetn(aresetn),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
		.wstrb(4'hf), .bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr),
		.arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
		.rresp(rresp), .eeprom_write(eeprom_write),
		.array_erase(array_erase), .array_wr_en(array_wr_en),
		.array_wr_addr(array_wr_addr), .array_wr_data(array_wr_data),
		.array_page(array_page), .load_word_addr(load_word_addr),
		.pointer_byte_select(pointer_byte_select), .cpu_halt(cpu_halt),
		.concurrent_read_blocked(concurrent_read_blocked),
		.store_ready_irq(store_ready_irq));
	flash_array_model fm (.aclk(aclk), .array_erase(array_erase),
		.array_page(array_page), .array_wr_en(array_wr_en),
		.array_wr_addr(array_wr_addr), .array_wr_data(array_wr_data));

	always #5 aclk = ~aclk;
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 30000) begin
			n_fail++;
			close_out();
		end
	end

	task automatic close_out();
		$display("Checks %0d, mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Bus write; e waits an edge first, k keeps bready for a chained store
	task automatic wr_raw(input logic [5:0] a, input logic [31:0] v,
		input bit e, input bit k);
		if (e)
			@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		forever begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'h0;
			if (wvalid && wready)
				wvalid <= 1'h0;
			if (bvalid)
				break;
		end
		r = bresp;
		if (!k)
			bready <= 1'h0;
	endtask

	task automatic wr(input logic [5:0] a, input logic [31:0] v);
		wr_raw(a, v, 1, 0);
	endtask

	task automatic rd(input logic [5:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		forever begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'h0;
			if (rvalid)
				break;
		end
		d = rdata;
		rready <= 1'h0;
	endtask

	// Command with irq enable, store right behind it
	task automatic cmd(input logic [4:0] c);
		wr_raw(`OFS_CONTROL, {24'h0, 3'h4, c}, 1, 1);
		wr_raw(`OFS_STORE, 32'h1, 0, 0);
	endtask

	task automatic setp(input logic [7:0] pg, input logic [5:0] wd);
		wr(`OFS_POINTER_LOW, {24'h0, pg[0], wd, 1'h0});
		wr(`OFS_POINTER_HIGH, {25'h0, pg[7:1]});
	endtask

	task automatic ld(input logic [7:0] pg, input logic [5:0] wd,
		input logic [15:0] v);
		setp(pg, wd);
		wr(`OFS_OPERAND_LOW, {24'h0, v[7:0]});
		wr(`OFS_OPERAND_HIGH, {24'h0, v[15:8]});
		cmd(`CMD_LOAD);
	endtask

	task automatic idle();
		repeat (100) begin
			rd(`OFS_CONTROL);
			if (d[0] === 1'h0)
				break;
		end
		`CHK("store enable", 1'h0, d[0])
		repeat (2) @(posedge aclk);
	endtask

	task automatic t_regs();
		rd(`OFS_CONTROL);
		`CHK("control reset", 32'h0, d)
		rd(`OFS_LOCK_BITS);
		`CHK("lock reset", 32'h3c, d)
		wr(6'h20, 32'h0);
		`CHK("unmapped resp", `RESP_SLVERR, r)
		wr(`OFS_POINTER_LOW, 32'h55);
		wr(`OFS_POINTER_HIGH, 32'h12);
		rd(`OFS_LOAD_ADDR);
		`CHK("pointer", 32'h1255, d)
		`CHK("byte select", 1'h1, pointer_byte_select)
		`CHK("load address", 14'h092a, load_word_addr)
	endtask

	task automatic t_page();
		ld(8'h10, 6'd5, 16'ha5a5);
		ld(8'h10, 6'd0, 16'h1234);
		ld(8'h10, 6'd63, 16'h0f0f);
		setp(8'h10, 6'd0);
		cmd(`CMD_ERASE);
		`CHK("no halt", 1'h0, cpu_halt)
		idle();
		`CHK("busy flag", 1'h1, concurrent_read_blocked)
		`CHK("ready request", 1'h1, store_ready_irq)
		cmd(`CMD_WRITE);
		setp(8'h33, 6'd0);
		idle();
		`CHK("word 5", 16'ha5a5, fm.mem[{8'h10, 6'd5}])
		`CHK("word 0", 16'h1234, fm.mem[{8'h10, 6'd0}])
		`CHK("word 63", 16'h0f0f, fm.mem[{8'h10, 6'd63}])
		`CHK("word 1", 16'hffff, fm.mem[{8'h10, 6'd1}])
	endtask

	task automatic t_clear();
		ld(8'h10, 6'd7, 16'h0000);
		eeprom_write <= 1'h1;
		repeat (3) @(posedge aclk);
		eeprom_write <= 1'h0;
		setp(8'h10, 6'd0);
		cmd(`CMD_ERASE);
		idle();
		cmd(`CMD_WRITE);
		idle();
		`CHK("cleared word 5", 16'hffff, fm.mem[{8'h10, 6'd5}])
		`CHK("dropped word 7", 16'hffff, fm.mem[{8'h10, 6'd7}])
		cmd(`CMD_REENABLE);
		idle();
		`CHK("busy cleared", 1'h0, concurrent_read_blocked)
	endtask

	task automatic t_refuse();
		n = fm.n_ops;
		cmd(5'h07);
		wr(`OFS_CONTROL, {27'h0, `CMD_ERASE});
		// One extra edge puts the store past the four-cycle window
		@(posedge aclk);
		wr(`OFS_STORE, 32'h1);
		rd(`OFS_CONTROL);
		`CHK("late store", 1'h0, d[0])
		`CHK("array idle", n, fm.n_ops)
	endtask

	task automatic t_lock();
		n = fm.n_ops;
		setp(8'h12, 6'd3);
		wr(`OFS_OPERAND_LOW, 32'hef);
		cmd(`CMD_LOCK_SET);
		idle();
		rd(`OFS_LOCK_BITS);
		`CHK("lock bits", 32'h2c, d)
		`CHK("pointer unused", n, fm.n_ops)
		setp(8'he0, 6'd0);
		cmd(`CMD_ERASE);
		`CHK("stall halt", 1'h1, cpu_halt)
		idle();
		`CHK("stall erase", 16'hffff, fm.mem[{8'he0, 6'd9}])
	endtask

	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'h1;
		t_regs();
		t_page();
		t_clear();
		t_refuse();
		t_lock();
		close_out();
	end
endmodule
